// File: design/flash_timing_pkg.sv
// constants for the code flash bank access timing block
// register map, field positions and reset values are shared by the design files
package flash_timing_pkg;
   // register byte offsets on the control bus
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_MASK = 8'h08;
   localparam logic [7:0] OFS_FAIL_ADDR = 8'h0c;
   // field positions in code_bank_access_config
   localparam int GAP_LSB = 27;
   localparam int WWS_LSB = 22;
   localparam int RWS_LSB = 17;
   localparam int POL_HI_BIT = 16;
   localparam int POL_MID_BIT = 15;
   localparam int POL_LO_BIT = 7;
   localparam int FIELD_W = 5;
   localparam int POL_W = 3;
   // reset values
   localparam logic [4:0] GAP_RESET = 5'h02;
   localparam logic [4:0] WWS_RESET = 5'h02;
   localparam logic [4:0] RWS_RESET = 5'h02;
   localparam logic [2:0] POL_RESET = 3'h7;
   // read-during-program policy encodings
   localparam logic [2:0] POL_ABORT_NOTIFY = 3'h4;
   localparam logic [2:0] POL_STALL_NOTIFY = 3'h6;
   // status and mask bit positions
   localparam int ST_RWE = 0;
   localparam int ST_ABORT = 1;
   localparam int ST_STALL = 2;
   localparam int ST_W = 3;
   // failing address field, double word aligned
   localparam int ADDR_W = 23;
   localparam int FAIL_LSB = 3;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: design/step_counter.sv
// loadable down counter that stops at zero
// assumes one clock and an active low asynchronous reset
`timescale 1ns/10ps
`default_nettype none
module step_counter (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic load,
   input wire logic [4:0] load_value,
   output logic [4:0] count_r,
   output logic zero
);
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         count_r <= 5'h00;
      end else if (load) begin
         count_r <= load_value;
      end else if (count_r != 5'h00) begin
         count_r <= count_r - 5'h01;
      end
   end

   assign zero = (count_r == 5'h00);
endmodule
`default_nettype wire

// File: design/code_flash_bank_access_timing.sv
// access timing and read-during-program handling for the code flash bank
// assumes an axi4-lite master for registers and one flash access requester
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module code_flash_bank_access_timing (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic acc_valid,
   input wire logic acc_write,
   input wire logic [22:0] acc_addr,
   output logic acc_ready,
   output logic acc_done_r,
   output logic acc_error_r,
   output logic [63:0] acc_rdata_r,
   output logic arr_start_r,
   output logic arr_write_r,
   output logic [22:0] arr_addr_r,
   input wire logic [63:0] arr_rdata,
   input wire logic pe_busy,
   output logic pe_abort_r,
   output logic irq
);
   typedef enum logic [1:0] {S_IDLE, S_STALL, S_ARRAY} state_t;

   state_t state_r;
   logic [4:0] gap_r, wws_r, rws_r;
   logic [2:0] pol_r;
   logic [2:0] status_r, mask_r, status_set, status_clr;
   logic [22:0] fail_addr_r;
   logic take, start_now, wait_zero, gap_zero;
   logic [4:0] wait_load;
   function automatic logic stalls(input logic [2:0] pol);
      stalls = pol[2];
   endfunction
   function automatic logic aborts(input logic [2:0] pol);
      aborts = (pol[2:1] == 2'b10);
   endfunction
   function automatic logic [31:0] byte_mask(input logic [3:0] strb);
      byte_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction
   // axi4-lite slave
   logic aw_held_r, w_held_r, wr_go;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r, wmask_r, cfg_word;
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready = !w_held_r && !s_axi_bvalid;
   assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         wmask_r <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            wmask_r <= byte_mask(s_axi_wstrb);
         end else if (wr_go) begin
            w_held_r <= 1'b0;
         end
      end
   end
   logic wr_mapped;
   assign wr_mapped = (aw_addr_r == flash_timing_pkg::OFS_CONFIG) || (aw_addr_r == flash_timing_pkg::OFS_STATUS)
      || (aw_addr_r == flash_timing_pkg::OFS_MASK) || (aw_addr_r == flash_timing_pkg::OFS_FAIL_ADDR);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= flash_timing_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? flash_timing_pkg::RESP_OKAY : flash_timing_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // single bank instance: only the code bank register is present
   assign cfg_word = ({gap_r, 27'h0} | {5'h0, wws_r, 22'h0} | {10'h0, rws_r, 17'h0})
      | {15'h0, pol_r[2], pol_r[1], 7'h0, pol_r[0], 7'h0};

   logic [31:0] cfg_new;
   assign cfg_new = (cfg_word & ~wmask_r) | (w_data_r & wmask_r);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         gap_r <= flash_timing_pkg::GAP_RESET;
         wws_r <= flash_timing_pkg::WWS_RESET;
         rws_r <= flash_timing_pkg::RWS_RESET;
         pol_r <= flash_timing_pkg::POL_RESET;
         mask_r <= 3'h0;
      end else if (wr_go) begin
         if (aw_addr_r == flash_timing_pkg::OFS_CONFIG) begin
            gap_r <= cfg_new[flash_timing_pkg::GAP_LSB +: flash_timing_pkg::FIELD_W];
            wws_r <= cfg_new[flash_timing_pkg::WWS_LSB +: flash_timing_pkg::FIELD_W];
            rws_r <= cfg_new[flash_timing_pkg::RWS_LSB +: flash_timing_pkg::FIELD_W];
            pol_r <= {cfg_new[flash_timing_pkg::POL_HI_BIT], cfg_new[flash_timing_pkg::POL_MID_BIT],
               cfg_new[flash_timing_pkg::POL_LO_BIT]};
         end
         if (aw_addr_r == flash_timing_pkg::OFS_MASK && wmask_r[0]) begin
            mask_r <= w_data_r[flash_timing_pkg::ST_W-1:0];
         end
      end
   end

   assign status_clr = (wr_go && aw_addr_r == flash_timing_pkg::OFS_STATUS && wmask_r[0])
      ? w_data_r[flash_timing_pkg::ST_W-1:0] : 3'h0;

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         status_r <= 3'h0;
      end else begin
         status_r <= (status_r & ~status_clr) | status_set;
      end
   end

   assign irq = |(status_r & mask_r);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= flash_timing_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= flash_timing_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            flash_timing_pkg::OFS_CONFIG: s_axi_rdata <= cfg_word;
            flash_timing_pkg::OFS_STATUS: s_axi_rdata <= {29'h0, status_r};
            flash_timing_pkg::OFS_MASK: s_axi_rdata <= {29'h0, mask_r};
            flash_timing_pkg::OFS_FAIL_ADDR: s_axi_rdata <= {9'h0, fail_addr_r[22:3], 3'h0};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= flash_timing_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // access sequencer
   assign acc_ready = (state_r == S_IDLE) && gap_zero;
   assign take = acc_valid && acc_ready;
   logic rdp_hit;
   assign rdp_hit = take && !acc_write && pe_busy;
   assign start_now = (take && !rdp_hit) || (state_r == S_STALL && !pe_busy);
   logic arr_write_nxt;
   assign arr_write_nxt = take ? acc_write : arr_write_r;
   assign wait_load = arr_write_nxt ? wws_r : rws_r;
   logic array_end;
   // a zero wait count ends the phase in the start cycle, so each wait state adds one cycle
   assign array_end = (state_r == S_ARRAY) && wait_zero;

   step_counter wait_ctr (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .load(start_now),
      .load_value(wait_load),
      .count_r(),
      .zero(wait_zero)
   );
   step_counter gap_ctr (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .load(array_end),
      .load_value(gap_r),
      .count_r(),
      .zero(gap_zero)
   );
   always_comb begin
      status_set = 3'h0;
      status_set[flash_timing_pkg::ST_RWE] = rdp_hit && !stalls(pol_r);
      status_set[flash_timing_pkg::ST_ABORT] = rdp_hit && (pol_r == flash_timing_pkg::POL_ABORT_NOTIFY);
      status_set[flash_timing_pkg::ST_STALL] = rdp_hit && (pol_r == flash_timing_pkg::POL_STALL_NOTIFY);
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= S_IDLE;
      end else begin
         unique case (state_r)
            S_IDLE: begin
               if (start_now) begin
                  state_r <= S_ARRAY;
               end else if (rdp_hit && stalls(pol_r)) begin
                  state_r <= S_STALL;
               end
            end
            S_STALL: begin
               if (start_now) begin
                  state_r <= S_ARRAY;
               end
            end
            S_ARRAY: begin
               if (array_end) begin
                  state_r <= S_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         arr_start_r <= 1'b0;
         arr_write_r <= 1'b0;
         arr_addr_r <= 23'h000000;
         pe_abort_r <= 1'b0;
      end else begin
         arr_start_r <= start_now;
         pe_abort_r <= rdp_hit && aborts(pol_r);
         if (take) begin
            arr_write_r <= acc_write;
            arr_addr_r <= acc_addr;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         acc_done_r <= 1'b0;
         acc_error_r <= 1'b0;
         acc_rdata_r <= 64'h0;
      end else begin
         acc_done_r <= array_end || (rdp_hit && !stalls(pol_r));
         acc_error_r <= rdp_hit && !stalls(pol_r);
         if (array_end && !arr_write_r) begin
            acc_rdata_r <= arr_rdata;
         end
      end
   end

   // only the first failing address is kept while the flag stands
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         fail_addr_r <= 23'h000000;
      end else if (status_set[flash_timing_pkg::ST_RWE] && !status_r[flash_timing_pkg::ST_RWE]) begin
         fail_addr_r <= {acc_addr[22:3], 3'h0};
      end
   end

   // assertion helpers: cycles since the last phase end and start
   logic [5:0] since_end_r, since_start_r;
   logic [4:0] gap_used_r, ws_used_r;
   logic seen_end_r;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         since_end_r <= 6'h00;
         since_start_r <= 6'h00;
         gap_used_r <= 5'h00;
         ws_used_r <= 5'h00;
         seen_end_r <= 1'b0;
      end else begin
         since_end_r <= array_end ? 6'h00 : (since_end_r == 6'h3f ? since_end_r : since_end_r + 6'h01);
         since_start_r <= start_now ? 6'h00 : since_start_r + 6'h01;
         if (array_end) begin
            gap_used_r <= gap_r;
            seen_end_r <= 1'b1;
         end
         if (start_now) begin
            ws_used_r <= wait_load;
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sequence rdp_error_seq;
      rdp_hit && !pol_r[2];
   endsequence

   chk_gap_hold: assert property (arr_start_r && seen_end_r && state_r == S_ARRAY && since_end_r < 6'h3f
      |-> since_end_r > {1'b0, gap_used_r}) else $error("array request inside the hold gap");
   chk_reset_defaults: assert property (@(posedge clk_sys) $rose(reset_n) |-> gap_r == 5'h02
      && wws_r == 5'h02 && rws_r == 5'h02 && pol_r == 3'h7) else $error("config reset value wrong");
   chk_write_waits: assert property (acc_done_r && !acc_error_r && arr_write_r
      |-> since_start_r == {1'b0, ws_used_r} + 6'h01) else $error("write wait states wrong");
   chk_read_waits: assert property (acc_done_r && !acc_error_r && !arr_write_r
      |-> since_start_r == {1'b0, ws_used_r} + 6'h01) else $error("read wait states wrong");
   chk_error_resp: assert property (rdp_error_seq |=> acc_done_r && acc_error_r
      && status_r[0] && !arr_start_r) else $error("read during program not refused");
   chk_abort_only: assert property (pe_abort_r |-> $past(pol_r[2:1] == 2'b10)
      && state_r == S_STALL) else $error("abort raised without abort policy");
   chk_abort_notify: assert property (rdp_hit && pol_r == 3'h4 |=> pe_abort_r
      && status_r[1] && !status_r[2]) else $error("abort notify missing");
   chk_stall_notify: assert property (rdp_hit && pol_r == 3'h6 |=> !pe_abort_r
      && status_r[2] && state_r == S_STALL) else $error("stall notify missing");
   chk_stall_quiet: assert property (rdp_hit && pol_r == 3'h7 |=> state_r == S_STALL
      && !pe_abort_r && $stable(status_r[2:1])) else $error("plain stall misbehaved");
   chk_first_fail: assert property (status_r[0] && !status_clr[0] |=> $stable(fail_addr_r))
      else $error("failing address overwritten");
   chk_reserved_zero: assert property (s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready
      && s_axi_araddr == 8'h00) |-> s_axi_rdata[14:8] == 7'h00) else $error("reserved bits not zero");
endmodule
`default_nettype wire

// File: tb/flash_array_model.sv
// flash array and program/erase engine standing behind the access timing block
// assumes one system clock; the bench starts program/erase with pe_go
`timescale 1ns/10ps
`default_nettype none
module flash_array_model #(parameter int PE_LEN = 40) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic pe_go,
   input wire logic arr_start_r,
   input wire logic acc_done_r,
   input wire logic [22:0] arr_addr_r,
   input wire logic pe_abort_r,
   output logic [63:0] arr_rdata,
   output logic pe_busy
);
   logic phase_r;
   logic [63:0] noise_r;
   int pe_cnt_r;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         phase_r <= 1'b0;
         noise_r <= 64'h0;
      end else begin
         noise_r <= {noise_r[62:0], ~noise_r[63]};
         if (arr_start_r) phase_r <= 1'b1;
         else if (acc_done_r) phase_r <= 1'b0;
      end
   end
   // data is only good while an array phase is open, otherwise it keeps changing
   assign arr_rdata = (phase_r || arr_start_r) ? {arr_addr_r, 9'h0a5, arr_addr_r, 9'h15a} : noise_r;
   // an abort ends the operation at once
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) pe_cnt_r <= 0;
      else if (pe_go) pe_cnt_r <= PE_LEN;
      else if (pe_abort_r) pe_cnt_r <= 0;
      else if (pe_cnt_r > 0) pe_cnt_r <= pe_cnt_r - 1;
   end
   assign pe_busy = pe_cnt_r > 0;
endmodule
`default_nettype wire

// File: tb/test_code_flash_bank_access_timing.sv
// self-checking bench for the code flash bank access timing block
// assumes the array model on the far side and this bench as bus master
`timescale 1ns/10ps
`default_nettype none
module test_code_flash_bank_access_timing;
   logic clk_sys, reset_n, pe_go;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
   logic acc_valid, acc_write, acc_ready, acc_done_r, acc_error_r, arr_start_r, arr_write_r, pe_busy, pe_abort_r;
   logic [22:0] acc_addr, arr_addr_r, fa;
   logic [63:0] acc_rdata_r, arr_rdata;
   logic [2:0] exp_st;
   logic wr_c, stalled;
   int errors = 0, tests_run = 0, cyc = 0;
   int take_c, st_c, dn_c, busy_c, n_take, n_done, n_abort, g_exp, w_exp, r_exp, ab, k;
   int tbl[5][3] = '{'{2, 2, 2}, '{0, 0, 0}, '{31, 31, 31}, '{3, 7, 3}, '{1, 0, 5}};
   logic [2:0] pols[6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};

   code_flash_bank_access_timing dut_u (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .acc_valid, .acc_write, .acc_addr, .acc_ready, .acc_done_r, .acc_error_r, .acc_rdata_r, .arr_start_r,
      .arr_write_r, .arr_addr_r, .arr_rdata, .pe_busy, .pe_abort_r, .irq);
   flash_array_model #(.PE_LEN(40)) array_u (.clk_sys, .reset_n, .pe_go, .arr_start_r, .acc_done_r,
      .arr_addr_r, .pe_abort_r, .arr_rdata, .pe_busy);

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) cyc <= cyc + 1;

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish;
      if (errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic hang(input string what);
      chk(what, 1, 0);
      tally_and_finish;
   endtask

   function automatic logic [1:0] resp_of(input logic [7:0] a);
      resp_of = (a > 8'h0c) ? flash_timing_pkg::RESP_SLVERR : flash_timing_pkg::RESP_OKAY;
   endfunction

   function automatic logic [31:0] cfg(input logic [4:0] g, input logic [4:0] w, input logic [4:0] r,
      input logic [2:0] p);
      cfg = 32'h0;
      cfg[flash_timing_pkg::GAP_LSB +: 5] = g;
      cfg[flash_timing_pkg::WWS_LSB +: 5] = w;
      cfg[flash_timing_pkg::RWS_LSB +: 5] = r;
      cfg[flash_timing_pkg::POL_HI_BIT] = p[2];
      cfg[flash_timing_pkg::POL_MID_BIT] = p[1];
      cfg[flash_timing_pkg::POL_LO_BIT] = p[0];
   endfunction

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (n == 100) hang("bvalid");
      s_axi_bready <= 1'b0;
      chk("bresp", resp_of(a), s_axi_bresp);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      int n;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (n == 100) hang("rvalid");
      s_axi_rready <= 1'b0;
      chk("rresp", resp_of(a), s_axi_rresp);
      chk("register", exp, s_axi_rdata);
   endtask

   // watches the access side between edges, where every output has settled
   always @(negedge clk_sys) if (reset_n) begin
      if (arr_start_r) begin
         chk("start", stalled ? busy_c + 2 : take_c, cyc);
         chk("arr_write", wr_c, arr_write_r);
         chk("arr_addr", acc_addr, arr_addr_r);
         st_c = cyc;
      end
      if (acc_done_r && acc_error_r) chk("error_time", take_c, cyc);
      else if (acc_done_r) begin
         chk("waits", st_c + (wr_c ? w_exp : r_exp) + 1, cyc);
         if (!wr_c) chk("acc_rdata", {acc_addr, 9'h0a5, acc_addr, 9'h15a}, acc_rdata_r);
         dn_c = cyc;
      end
      if (acc_done_r) n_done++;
      if (pe_busy) busy_c = cyc;
      if (pe_abort_r) n_abort++;
      if (acc_valid && acc_ready) begin
         if (dn_c > 0) chk("gap", dn_c + g_exp + 1, cyc + 1);
         take_c = cyc + 1;
         wr_c = acc_write;
         stalled = pe_busy && !acc_write;
         n_take++;
      end
   end

   // request held high so that each access follows the last as soon as allowed
   task automatic burst(input logic wr, input int n);
      dn_c = 0;
      n_take = 0;
      n_done = 0;
      @(posedge clk_sys);
      acc_write <= wr;
      acc_valid <= 1'b1;
      for (k = 0; k < 3000 && n_take < n; k++) @(posedge clk_sys);
      acc_valid <= 1'b0;
      for (k = 0; k < 3000 && n_done < n; k++) @(posedge clk_sys);
      if (n_done != n) hang("acc_done_r");
   endtask

   initial begin
      reset_n = 1'b0;
      pe_go = 1'b0;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, acc_valid, acc_write} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, acc_addr} = '0;
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(flash_timing_pkg::OFS_CONFIG, cfg(5'h02, 5'h02, 5'h02, 3'h7));
      rd(flash_timing_pkg::OFS_STATUS, 32'h0);
      axi_wr(flash_timing_pkg::OFS_CONFIG, 32'hffffffff);
      rd(flash_timing_pkg::OFS_CONFIG, cfg(5'h1f, 5'h1f, 5'h1f, 3'h7));
      rd(8'h10, 32'h0);
      axi_wr(8'h10, 32'h0);
      foreach (tbl[i]) begin
         g_exp = tbl[i][0];
         w_exp = tbl[i][1];
         r_exp = tbl[i][2];
         axi_wr(flash_timing_pkg::OFS_CONFIG, cfg(5'(g_exp), 5'(w_exp), 5'(r_exp), 3'h7));
         acc_addr <= 23'h05a5a5 + 23'(i);
         burst(1'b1, 3);
         burst(1'b0, 3);
      end
      g_exp = 2;
      w_exp = 2;
      r_exp = 2;
      foreach (pols[i]) begin
         axi_wr(flash_timing_pkg::OFS_CONFIG, cfg(5'h02, 5'h02, 5'h02, pols[i]));
         rd(flash_timing_pkg::OFS_CONFIG, cfg(5'h02, 5'h02, 5'h02, pols[i]));
         ab = n_abort;
         @(posedge clk_sys);
         pe_go <= 1'b1;
         acc_addr <= 23'h012345 + 23'(i * 8);
         @(posedge clk_sys);
         pe_go <= 1'b0;
         fa = acc_addr;
         burst(1'b0, 1);
         chk("abort_count", 64'(pols[i][2:1] == 2'b10), 64'(n_abort - ab));
         if (!pols[i][2]) begin
            acc_addr <= fa ^ 23'h000f08;
            burst(1'b0, 1);
            rd(flash_timing_pkg::OFS_FAIL_ADDR, {9'h0, fa[22:3], 3'h0});
         end
         exp_st = !pols[i][2] ? 3'h1 : (pols[i] == 3'h4) ? 3'h2 : (pols[i] == 3'h6) ? 3'h4 : 3'h0;
         rd(flash_timing_pkg::OFS_STATUS, {29'h0, exp_st});
         axi_wr(flash_timing_pkg::OFS_MASK, 32'h7);
         chk("irq", |exp_st, irq);
         axi_wr(flash_timing_pkg::OFS_MASK, 32'h0);
         chk("irq_masked", 0, irq);
         axi_wr(flash_timing_pkg::OFS_STATUS, 32'h7);
         rd(flash_timing_pkg::OFS_STATUS, 32'h0);
         for (k = 0; k < 200 && pe_busy; k++) @(posedge clk_sys);
         if (pe_busy) hang("pe_busy");
      end
      tally_and_finish;
   end
endmodule
`default_nettype wire
